/* core/cpu_bitop_shift_load_exec.sv */
/*
 * Executes the bit, shift, flag, move and indirect-load subset of an 8-bit core,
 * holding the working registers, status flags and program counter.
 * Assumes a decoder that offers one operation with i_valid and waits for o_ready,
 * an I/O space answering i_io_rdata in the same cycle as o_io_rd, and a data memory
 * answering i_mem_rdata in the same cycle as o_mem_rd.
 */
`default_nettype none

module cpu_bitop_shift_load_exec
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Operation from the decoder
    input wire logic i_valid,
    input wire exec_pkg::op_t i_op,
    input wire logic [4:0] i_rd,
    input wire logic [4:0] i_rr,
    input wire logic [2:0] i_bit,
    input wire logic [4:0] i_io_addr,
    input wire logic [6:0] i_offset,
    input wire logic [1:0] i_ptr_sel,
    output logic o_ready,
    // Architectural state
    output logic [15:0] o_pc,
    output logic [7:0] o_flags,
    // Register read-back
    input wire logic [4:0] i_peek_addr,
    output logic [7:0] o_peek_data,
    // I/O space
    output logic [4:0] o_io_addr,
    output logic o_io_rd,
    input wire logic [7:0] i_io_rdata,
    output logic o_io_wr,
    output logic [7:0] o_io_wdata,
    // Data memory
    output logic [15:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic [7:0] i_mem_rdata
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    exec_pkg::state_t state;
    exec_pkg::state_t next_state;
    logic [7:0] regs [exec_pkg::NREGS];
    logic [7:0] next_regs [exec_pkg::NREGS];
    logic [15:0] next_pc;
    logic [7:0] next_flags;
    logic [7:0] next_peek_data;
    logic [4:0] next_io_addr;
    logic next_io_rd;
    logic next_io_wr;
    logic [7:0] next_io_wdata;
    logic [15:0] next_mem_addr;
    logic next_mem_rd;
    logic [4:0] load_dest;
    logic [4:0] next_load_dest;
    logic [2:0] io_bit;
    logic [2:0] next_io_bit;
    logic io_set;
    logic next_io_set;

    logic accept;
    logic [4:0] ptr_lo;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [15:0] offset_ext;
    exec_pkg::shift_kind_t shift_kind;
    logic shift_fill;
    logic [7:0] shift_result;
    logic shift_c;
    logic shift_z;
    logic shift_n;
    logic shift_v;

    assign accept = i_valid && (state == exec_pkg::ST_READY);
    assign offset_ext = {{(16 - exec_pkg::OFFS_W){i_offset[exec_pkg::OFFS_W - 1]}}, i_offset};

    ////////////////////////////////////////////////////////////////////////////////
    // Shifter

    always_comb
    begin
        case (i_op)
            exec_pkg::OP_LOGIC_SHIFT_LEFT:
            begin
                shift_kind = exec_pkg::SHIFT_LEFT;
                shift_fill = 1'b0;
            end
            exec_pkg::OP_ROTATE_LEFT_CARRY:
            begin
                shift_kind = exec_pkg::SHIFT_LEFT;
                shift_fill = o_flags[exec_pkg::FLAG_C];
            end
            exec_pkg::OP_ROTATE_RIGHT_CARRY:
            begin
                shift_kind = exec_pkg::SHIFT_RIGHT;
                shift_fill = o_flags[exec_pkg::FLAG_C];
            end
            exec_pkg::OP_ARITH_SHIFT_RIGHT:
            begin
                shift_kind = exec_pkg::SHIFT_ARITH;
                shift_fill = 1'b0;
            end
            default:
            begin
                shift_kind = exec_pkg::SHIFT_RIGHT;
                shift_fill = 1'b0;
            end
        endcase
    end

    shift_unit u_shift
    (
        .i_value(regs[i_rd]),
        .i_kind(shift_kind),
        .i_fill(shift_fill),
        .o_result(shift_result),
        .o_carry(shift_c),
        .o_zero(shift_z),
        .o_negative(shift_n),
        .o_overflow(shift_v)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer selection

    always_comb
    begin
        case (i_ptr_sel)
            exec_pkg::PTR_SEL_X: ptr_lo = exec_pkg::PTR_X_LO;
            exec_pkg::PTR_SEL_Y: ptr_lo = exec_pkg::PTR_Y_LO;
            default: ptr_lo = exec_pkg::PTR_Z_LO;
        endcase
        ptr_val = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
        if (i_op == exec_pkg::OP_LOAD_PRE_DEC)
            ptr_new = ptr_val - 16'h0001;
        else
            ptr_new = ptr_val + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        next_state = state;
        next_regs = regs;
        next_pc = o_pc;
        next_flags = o_flags;
        next_io_addr = o_io_addr;
        next_io_rd = 1'b0;
        next_io_wr = 1'b0;
        next_io_wdata = o_io_wdata;
        next_mem_addr = o_mem_addr;
        next_mem_rd = 1'b0;
        next_load_dest = load_dest;
        next_io_bit = io_bit;
        next_io_set = io_set;

        case (state)
            exec_pkg::ST_READY:
            begin
                if (accept)
                begin
                    next_pc = o_pc + 16'h0001;
                    case (i_op)
                        exec_pkg::OP_BRANCH_IRQ_ON:
                        begin
                            if (o_flags[exec_pkg::FLAG_I])
                            begin
                                next_pc = o_pc + offset_ext + 16'h0001;
                                next_state = exec_pkg::ST_BRANCH_FLUSH;
                            end
                        end
                        exec_pkg::OP_BRANCH_IRQ_OFF:
                        begin
                            if (!o_flags[exec_pkg::FLAG_I])
                            begin
                                next_pc = o_pc + offset_ext + 16'h0001;
                                next_state = exec_pkg::ST_BRANCH_FLUSH;
                            end
                        end
                        exec_pkg::OP_IO_BIT_SET, exec_pkg::OP_IO_BIT_CLEAR:
                        begin
                            // Read first so the other bits of the register survive
                            next_io_addr = i_io_addr;
                            next_io_rd = 1'b1;
                            next_io_bit = i_bit;
                            next_io_set = (i_op == exec_pkg::OP_IO_BIT_SET);
                            next_state = exec_pkg::ST_IO_MODIFY;
                        end
                        exec_pkg::OP_LOGIC_SHIFT_LEFT, exec_pkg::OP_LOGIC_SHIFT_RIGHT,
                        exec_pkg::OP_ROTATE_LEFT_CARRY, exec_pkg::OP_ROTATE_RIGHT_CARRY,
                        exec_pkg::OP_ARITH_SHIFT_RIGHT:
                        begin
                            next_regs[i_rd] = shift_result;
                            next_flags[exec_pkg::FLAG_C] = shift_c;
                            next_flags[exec_pkg::FLAG_Z] = shift_z;
                            next_flags[exec_pkg::FLAG_N] = shift_n;
                            next_flags[exec_pkg::FLAG_V] = shift_v;
                        end
                        exec_pkg::OP_FLAG_SET:
                            next_flags[i_bit] = 1'b1;
                        exec_pkg::OP_FLAG_CLEAR:
                            next_flags[i_bit] = 1'b0;
                        exec_pkg::OP_BIT_TO_TRANSFER_FLAG:
                            next_flags[exec_pkg::FLAG_T] = regs[i_rr][i_bit];
                        exec_pkg::OP_TRANSFER_FLAG_TO_BIT:
                            next_regs[i_rd][i_bit] = o_flags[exec_pkg::FLAG_T];
                        exec_pkg::OP_REG_COPY:
                            next_regs[i_rd] = regs[i_rr];
                        exec_pkg::OP_REG_PAIR_COPY:
                        begin
                            // Pairs are even-aligned; bit 0 of the indices is ignored
                            next_regs[{i_rd[4:1], 1'b0}] = regs[{i_rr[4:1], 1'b0}];
                            next_regs[{i_rd[4:1], 1'b1}] = regs[{i_rr[4:1], 1'b1}];
                        end
                        exec_pkg::OP_LOAD_POST_INC:
                        begin
                            next_mem_addr = ptr_val;
                            next_mem_rd = 1'b1;
                            next_regs[ptr_lo] = ptr_new[7:0];
                            next_regs[ptr_lo + 5'h01] = ptr_new[15:8];
                            next_load_dest = i_rd;
                            next_state = exec_pkg::ST_LOAD_WAIT;
                        end
                        exec_pkg::OP_LOAD_PRE_DEC:
                        begin
                            next_mem_addr = ptr_new;
                            next_mem_rd = 1'b1;
                            next_regs[ptr_lo] = ptr_new[7:0];
                            next_regs[ptr_lo + 5'h01] = ptr_new[15:8];
                            next_load_dest = i_rd;
                            next_state = exec_pkg::ST_LOAD_WAIT;
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            exec_pkg::ST_BRANCH_FLUSH:
                next_state = exec_pkg::ST_READY;
            exec_pkg::ST_IO_MODIFY:
            begin
                next_io_wdata = i_io_rdata;
                next_io_wdata[io_bit] = io_set;
                next_io_wr = 1'b1;
                next_state = exec_pkg::ST_READY;
            end
            exec_pkg::ST_LOAD_WAIT:
            begin
                // A load into a pointer byte overrides the pointer update
                next_regs[load_dest] = i_mem_rdata;
                next_state = exec_pkg::ST_READY;
            end
            default:
                next_state = exec_pkg::ST_READY;
        endcase

        next_peek_data = next_regs[i_peek_addr];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state <= exec_pkg::ST_READY;
            o_ready <= 1'b1;
            o_pc <= exec_pkg::PC_RESET;
            o_flags <= exec_pkg::FLAGS_RESET;
            o_peek_data <= 8'h00;
            o_io_addr <= 5'h00;
            o_io_rd <= 1'b0;
            o_io_wr <= 1'b0;
            o_io_wdata <= 8'h00;
            o_mem_addr <= 16'h0000;
            o_mem_rd <= 1'b0;
            load_dest <= 5'h00;
            io_bit <= 3'h0;
            io_set <= 1'b0;
            for (int i = 0; i < exec_pkg::NREGS; i++)
                regs[i] <= 8'h00;
        end
        else
        begin
            state <= next_state;
            o_ready <= (next_state == exec_pkg::ST_READY);
            o_pc <= next_pc;
            o_flags <= next_flags;
            o_peek_data <= next_peek_data;
            o_io_addr <= next_io_addr;
            o_io_rd <= next_io_rd;
            o_io_wr <= next_io_wr;
            o_io_wdata <= next_io_wdata;
            o_mem_addr <= next_mem_addr;
            o_mem_rd <= next_mem_rd;
            load_dest <= next_load_dest;
            io_bit <= next_io_bit;
            io_set <= next_io_set;
            regs <= next_regs;
        end
    end

endmodule : cpu_bitop_shift_load_exec

`default_nettype wire

/* core/exec_pkg.sv */
/*
 * Constants and types shared by the instruction execution block and its shifter.
 * Assumes a decoder upstream that presents one operation at a time with its operand fields.
 */
`default_nettype none

package exec_pkg;

    localparam int PC_W = 16;
    localparam int OFFS_W = 7;
    localparam int NREGS = 32;

    // Flag positions in o_flags
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Pointer pairs: low byte index of X, Y, Z
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;

    localparam logic [1:0] PTR_SEL_X = 2'h0;
    localparam logic [1:0] PTR_SEL_Y = 2'h1;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_BRANCH_IRQ_ON,
        OP_BRANCH_IRQ_OFF,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_TRANSFER_FLAG_TO_BIT,
        OP_REG_COPY,
        OP_REG_PAIR_COPY,
        OP_LOAD_POST_INC,
        OP_LOAD_PRE_DEC
    } op_t;

    typedef enum logic [1:0] {
        SHIFT_LEFT,
        SHIFT_RIGHT,
        SHIFT_ARITH
    } shift_kind_t;

    typedef enum {
        ST_READY,
        ST_BRANCH_FLUSH,
        ST_IO_MODIFY,
        ST_LOAD_WAIT
    } state_t;

endpackage : exec_pkg

`default_nettype wire

/* core/shift_unit.sv */
/*
 * Combinational shifter for the one-bit shifts and rotates, with the flags they produce.
 * Assumes the caller chooses whether the old carry or zero enters the vacated bit of the left and right shifts.
 */
`default_nettype none

module shift_unit
(
    // Operand
    input wire logic [7:0] i_value,
    input wire exec_pkg::shift_kind_t i_kind,
    input wire logic i_fill,
    // Result
    output logic [7:0] o_result,
    output logic o_carry,
    output logic o_zero,
    output logic o_negative,
    output logic o_overflow
);

    always_comb
    begin
        case (i_kind)
            exec_pkg::SHIFT_LEFT:
            begin
                o_result = {i_value[6:0], i_fill};
                o_carry = i_value[7];
            end
            exec_pkg::SHIFT_RIGHT:
            begin
                o_result = {i_fill, i_value[7:1]};
                o_carry = i_value[0];
            end
            exec_pkg::SHIFT_ARITH:
            begin
                // Sign bit stays put
                o_result = {i_value[7], i_value[7:1]};
                o_carry = i_value[0];
            end
            default:
            begin
                o_result = i_value;
                o_carry = 1'b0;
            end
        endcase
        o_zero = (o_result == 8'h00);
        o_negative = o_result[7];
        o_overflow = o_result[7] ^ o_carry;
    end

endmodule : shift_unit

`default_nettype wire

/* verification/exec_checker_assertions.sv */
/* Port checker for the execution block, bound to every instance.
   Assumes one clock and a synchronous active-high reset. */
`default_nettype none

module exec_checker
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Operation and state
    input wire logic i_valid,
    input wire exec_pkg::op_t i_op,
    input wire logic [2:0] i_bit,
    input wire logic [4:0] i_io_addr,
    input wire logic [6:0] i_offset,
    input wire logic o_ready,
    input wire logic [15:0] o_pc,
    input wire logic [7:0] o_flags,
    // I/O and memory
    input wire logic [4:0] o_io_addr,
    input wire logic o_io_rd,
    input wire logic [7:0] i_io_rdata,
    input wire logic o_io_wr,
    input wire logic [7:0] o_io_wdata,
    input wire logic o_mem_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    logic tk;
    assign tk = i_valid && o_ready;
    ////////////////////////////////////////////////////////////
    property p_io_take;
        tk && i_op inside {exec_pkg::OP_IO_BIT_SET, exec_pkg::OP_IO_BIT_CLEAR} |=> o_io_rd && !o_ready
            && o_io_addr == $past(i_io_addr) && o_flags == $past(o_flags) ##1 o_io_wr && o_ready && $stable(o_flags);
    endproperty
    a_io_take: assert property (p_io_take) else $error("io access order wrong");
    property p_io_set;
        tk && i_op == exec_pkg::OP_IO_BIT_SET |=> ##1 o_io_wdata == ($past(i_io_rdata) | (8'h01 << $past(i_bit, 2)));
    endproperty
    a_io_set: assert property (p_io_set) else $error("io set data wrong");
    property p_io_clr;
        tk && i_op == exec_pkg::OP_IO_BIT_CLEAR |=> ##1 o_io_wdata == ($past(i_io_rdata) & ~(8'h01 << $past(i_bit, 2)));
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io clear data wrong");
    property p_br_on;
        tk && i_op == exec_pkg::OP_BRANCH_IRQ_ON && o_flags[exec_pkg::FLAG_I]
            |=> !o_ready && o_pc == $past(o_pc) + 16'($signed($past(i_offset))) + 16'h0001 ##1 o_ready;
    endproperty
    a_br_on: assert property (p_br_on) else $error("taken branch wrong");
    property p_br_off;
        tk && i_op == exec_pkg::OP_BRANCH_IRQ_OFF && !o_flags[exec_pkg::FLAG_I]
            |=> !o_ready && o_pc == $past(o_pc) + 16'($signed($past(i_offset))) + 16'h0001 ##1 o_ready;
    endproperty
    a_br_off: assert property (p_br_off) else $error("taken branch wrong");
    property p_untaken;
        tk && (i_op == exec_pkg::OP_BRANCH_IRQ_ON) != o_flags[exec_pkg::FLAG_I]
            && i_op inside {exec_pkg::OP_BRANCH_IRQ_ON, exec_pkg::OP_BRANCH_IRQ_OFF}
            |=> o_ready && o_pc == $past(o_pc) + 16'h0001 && o_flags == $past(o_flags);
    endproperty
    a_untaken: assert property (p_untaken) else $error("untaken branch wrong");
    property p_shift;
        tk && i_op inside {[exec_pkg::OP_LOGIC_SHIFT_LEFT:exec_pkg::OP_ARITH_SHIFT_RIGHT]}
            |=> o_ready && o_flags[3] == (o_flags[2] ^ o_flags[0]) && o_flags[7:4] == $past(o_flags[7:4]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift flags wrong");
    property p_flag;
        tk && i_op == exec_pkg::OP_FLAG_SET |=> o_flags == ($past(o_flags) | (8'h01 << $past(i_bit)));
    endproperty
    a_flag: assert property (p_flag) else $error("flag set wrong");
    property p_flag_clr;
        tk && i_op == exec_pkg::OP_FLAG_CLEAR |=> o_flags == ($past(o_flags) & ~(8'h01 << $past(i_bit)));
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
    property p_to_t;
        tk && i_op == exec_pkg::OP_BIT_TO_TRANSFER_FLAG |=> o_ready && {o_flags[7], o_flags[5:0]}
            == {$past(o_flags[7]), $past(o_flags[5:0])};
    endproperty
    a_to_t: assert property (p_to_t) else $error("transfer flag op wrong");
    property p_load;
        tk && i_op inside {exec_pkg::OP_LOAD_POST_INC, exec_pkg::OP_LOAD_PRE_DEC} |=> o_mem_rd && !o_ready
            && o_flags == $past(o_flags) ##1 !o_mem_rd && o_ready && $stable(o_flags);
    endproperty
    a_load: assert property (p_load) else $error("load timing wrong");
    property p_copy;
        tk && i_op inside {[exec_pkg::OP_TRANSFER_FLAG_TO_BIT:exec_pkg::OP_REG_PAIR_COPY]}
            |=> o_ready && o_flags == $past(o_flags) && o_pc == $past(o_pc) + 16'h0001;
    endproperty
    a_copy: assert property (p_copy) else $error("copy op wrong");
    c_br: cover property (tk && i_op == exec_pkg::OP_BRANCH_IRQ_ON && o_flags[exec_pkg::FLAG_I]);
    c_io: cover property (o_io_wr);
    c_mem: cover property (o_mem_rd);
endmodule : exec_checker

bind cpu_bitop_shift_load_exec exec_checker chk
(
    .i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op), .i_bit(i_bit), .i_io_addr(i_io_addr),
    .i_offset(i_offset), .o_ready(o_ready), .o_pc(o_pc), .o_flags(o_flags), .o_io_addr(o_io_addr),
    .o_io_rd(o_io_rd), .i_io_rdata(i_io_rdata), .o_io_wr(o_io_wr), .o_io_wdata(o_io_wdata), .o_mem_rd(o_mem_rd)
);

`default_nettype wire

/* verification/tb.sv */
/* Self-checking bench for the execution block with a register model.
   Assumes I/O and memory answer in the cycle of their read strobe. */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_valid = 1'b0;
    exec_pkg::op_t i_op = exec_pkg::OP_NOP;
    logic [4:0] i_rd = 5'h00;
    logic [4:0] i_rr = 5'h00;
    logic [4:0] i_io_addr = 5'h00;
    logic [4:0] i_peek_addr = 5'h00;
    logic [2:0] i_bit = 3'h0;
    logic [6:0] i_offset = 7'h00;
    logic [1:0] i_ptr_sel = 2'h0;
    logic [7:0] i_io_rdata;
    logic [7:0] i_mem_rdata;
    logic o_ready;
    logic o_io_rd;
    logic o_io_wr;
    logic o_mem_rd;
    logic [15:0] o_pc;
    logic [15:0] o_mem_addr;
    logic [7:0] o_flags;
    logic [7:0] o_peek_data;
    logic [7:0] o_io_wdata;
    logic [4:0] o_io_addr;
    logic [7:0] io_mem [32];
    logic [7:0] regs [32];
    logic [7:0] flags = 8'h00;
    logic [15:0] pc = 16'h0000;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 32'h4D4ACD6D;
    always #12.5 i_clk = ~i_clk;
    cpu_bitop_shift_load_exec dut
    (
        .i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op), .i_rd(i_rd), .i_rr(i_rr),
        .i_bit(i_bit), .i_io_addr(i_io_addr), .i_offset(i_offset), .i_ptr_sel(i_ptr_sel), .o_ready(o_ready),
        .o_pc(o_pc), .o_flags(o_flags), .i_peek_addr(i_peek_addr), .o_peek_data(o_peek_data),
        .o_io_addr(o_io_addr), .o_io_rd(o_io_rd), .i_io_rdata(i_io_rdata), .o_io_wr(o_io_wr),
        .o_io_wdata(o_io_wdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata)
    );
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] mem_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : mem_val
    // Read data is inverted outside the strobe so a late or early sample shows
    assign i_mem_rdata = o_mem_rd ? mem_val(o_mem_addr) : ~mem_val(o_mem_addr);
    assign i_io_rdata = o_io_rd ? io_mem[o_io_addr] : ~io_mem[o_io_addr];
    always @(posedge i_clk)
    begin
        if (o_io_wr === 1'b1)
            io_mem[o_io_addr] <= o_io_wdata;
    end
    function automatic logic [8:0] shift(input exec_pkg::op_t op, input logic [7:0] v, input logic c);
        case (op)
            exec_pkg::OP_LOGIC_SHIFT_LEFT: return {v[7], v[6:0], 1'b0};
            exec_pkg::OP_LOGIC_SHIFT_RIGHT: return {v[0], 1'b0, v[7:1]};
            exec_pkg::OP_ROTATE_LEFT_CARRY: return {v[7], v[6:0], c};
            exec_pkg::OP_ROTATE_RIGHT_CARRY: return {v[0], c, v[7:1]};
            default: return {v[0], v[7], v[7:1]};
        endcase
    endfunction : shift
    ////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp16
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp16({8'h00, got}, {8'h00, exp});
    endtask : cmp8
    task automatic peek(input logic [4:0] r);
        i_peek_addr = r;
        @(posedge i_clk);
        #1;
        cmp8(o_peek_data, regs[r]);
    endtask : peek
    task automatic issue(input exec_pkg::op_t op, input logic [4:0] rd, input logic [4:0] rr,
        input logic [2:0] b, input logic [6:0] off, input logic [1:0] ps);
        logic two;
        logic [8:0] s;
        logic [4:0] lo;
        logic [15:0] p;
        logic [7:0] eio;
        int n;
        two = 1'b0;
        pc = pc + 16'h0001;
        eio = io_mem[rr];
        lo = ps == exec_pkg::PTR_SEL_X ? exec_pkg::PTR_X_LO : ps == exec_pkg::PTR_SEL_Y ? exec_pkg::PTR_Y_LO
            : exec_pkg::PTR_Z_LO;
        case (op)
            exec_pkg::OP_BRANCH_IRQ_ON, exec_pkg::OP_BRANCH_IRQ_OFF:
            begin
                two = flags[exec_pkg::FLAG_I] == (op == exec_pkg::OP_BRANCH_IRQ_ON);
                if (two)
                    pc = pc + 16'($signed(off));
            end
            exec_pkg::OP_IO_BIT_SET, exec_pkg::OP_IO_BIT_CLEAR:
            begin
                two = 1'b1;
                eio[b] = op == exec_pkg::OP_IO_BIT_SET;
            end
            exec_pkg::OP_FLAG_SET: flags[b] = 1'b1;
            exec_pkg::OP_FLAG_CLEAR: flags[b] = 1'b0;
            exec_pkg::OP_BIT_TO_TRANSFER_FLAG: flags[exec_pkg::FLAG_T] = regs[rr][b];
            exec_pkg::OP_TRANSFER_FLAG_TO_BIT: regs[rd][b] = flags[exec_pkg::FLAG_T];
            exec_pkg::OP_REG_COPY: regs[rd] = regs[rr];
            exec_pkg::OP_REG_PAIR_COPY:
            begin
                p = {regs[{rr[4:1], 1'b1}], regs[{rr[4:1], 1'b0}]};
                {regs[{rd[4:1], 1'b1}], regs[{rd[4:1], 1'b0}]} = p;
            end
            exec_pkg::OP_LOAD_POST_INC, exec_pkg::OP_LOAD_PRE_DEC:
            begin
                two = 1'b1;
                p = {regs[lo + 5'h01], regs[lo]} - {15'h0000, op == exec_pkg::OP_LOAD_PRE_DEC};
                s[7:0] = mem_val(p);
                p = p + {15'h0000, op == exec_pkg::OP_LOAD_POST_INC};
                {regs[lo + 5'h01], regs[lo]} = p;
                regs[rd] = s[7:0];
            end
            exec_pkg::OP_NOP: ;
            default:
            begin
                s = shift(op, regs[rd], flags[exec_pkg::FLAG_C]);
                regs[rd] = s[7:0];
                flags[3:0] = {s[7] ^ s[8], s[7], s[7:0] == 8'h00, s[8]};
            end
        endcase
        i_op = op;
        i_rd = rd;
        i_rr = rr;
        i_io_addr = rr;
        i_bit = b;
        i_offset = off;
        i_ptr_sel = ps;
        i_valid = 1'b1;
        @(posedge i_clk);
        #1;
        i_valid = 1'b0;
        cmp8({7'h00, o_ready}, {7'h00, ~two});
        n = 0;
        while (o_ready !== 1'b1)
        begin
            n++;
            if (n > 8)
            begin
                error_cnt++;
                conclude();
            end
            @(posedge i_clk);
            #1;
        end
        cmp16(o_pc, pc);
        cmp8(o_flags, flags);
        peek(rd);
        peek(rd ^ 5'h01);
        peek(lo);
        peek(lo + 5'h01);
        cmp8(io_mem[rr], eio);
    endtask : issue
    ////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 32; i++)
        begin
            regs[i] = 8'h00;
            io_mem[i] = 8'($random(seed));
        end
        repeat (20) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        cmp16(o_pc, 16'h0000);
        cmp8(o_flags, 8'h00);
        for (int i = 0; i < 32; i++)
            issue(exec_pkg::OP_LOAD_PRE_DEC, 5'(i), 5'h00, 3'h0, 7'h00, 2'(i));
        for (int i = 0; i < 16; i++)
            issue(exec_pkg::op_t'(i[0] ? exec_pkg::OP_FLAG_CLEAR : exec_pkg::OP_FLAG_SET), 5'h00, 5'h00,
                3'(i / 2), 7'h00, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            issue(exec_pkg::op_t'(i[0] ? exec_pkg::OP_FLAG_SET : exec_pkg::OP_FLAG_CLEAR), 5'h00, 5'h00, 3'h7,
                7'h00, 2'h0);
            issue(exec_pkg::op_t'(i[1] ? exec_pkg::OP_BRANCH_IRQ_ON : exec_pkg::OP_BRANCH_IRQ_OFF), 5'h00, 5'h00,
                3'h0, i[0] ? 7'h40 : 7'h3F, 2'h0);
            issue(exec_pkg::op_t'(i[0] ? exec_pkg::OP_IO_BIT_CLEAR : exec_pkg::OP_IO_BIT_SET), 5'h00, 5'h1F,
                3'(i * 7), 7'h00, 2'h0);
        end
        repeat (400)
            issue(exec_pkg::op_t'(5'($unsigned($random(seed)) % 18)), 5'($random(seed)), 5'($random(seed)),
                3'($random(seed)), 7'($random(seed)), 2'($random(seed)));
        conclude();
    end
endmodule : tb

`default_nettype wire
